// file: drb_consts.svh
// Constants for the 32x4 distributed RAM block and its register slave.
// Included by the package and the block; holds definitions only.
`ifndef DRB_CONSTS_SVH
`define DRB_CONSTS_SVH

// Array shape
`define DRB_WORDS        32
`define DRB_DW           4
`define DRB_AW           5

// Register byte addresses
`define DRB_OFF_CTRL     32'h0000_0000
`define DRB_OFF_STATUS   32'h0000_0004
`define DRB_OFF_CLEAR    32'h0000_0008

// Control field positions and reset value
`define DRB_CTRL_W       3
`define DRB_CTRL_SYNC    0
`define DRB_CTRL_SINGLE  1
`define DRB_CTRL_CFG     2
`define DRB_CTRL_RST     3'h0

// Status field positions
`define DRB_ST_SYNC      0
`define DRB_ST_SINGLE    1
`define DRB_ST_CFG       2
`define DRB_ST_WCLK      3
`define DRB_ST_WEN_N     4
`define DRB_ST_ADDR_LO   8
`define DRB_ST_ADDR_HI   12
`define DRB_ST_DATA_LO   16
`define DRB_ST_DATA_HI   19

// AXI responses
`define DRB_RESP_OKAY    2'h0
`define DRB_RESP_DECERR  2'h3

`endif

// file: drb_pkg.sv
// Types for the 32x4 distributed RAM block.
// Assumes drb_consts.svh is on the include path.
`include "drb_consts.svh"

package drb_pkg;

   typedef struct packed {
      logic [`DRB_CTRL_W-1:0]            ctrl;
      logic                              sync1;
      logic                              sync2;
      logic                              sync3;
      logic                              wclk_s;
      logic [`DRB_AW-1:0]                fe_addr;
      logic                              fe_wen_n;
      logic [`DRB_DW-1:0]                fe_data;
      logic [`DRB_WORDS-1:0][`DRB_DW-1:0] mem;
      logic [`DRB_DW-1:0]                rd_data;
      logic                              rd_data_oe;
      logic [`DRB_DW-1:0]                port_data_out;
      logic                              port_data_oe;
      logic                              aw_rdy;
      logic                              aw_got;
      logic [31:0]                       aw_addr;
      logic                              w_rdy;
      logic                              w_got;
      logic [31:0]                       w_data;
      logic [3:0]                        w_strb;
      logic                              bvalid;
      logic [1:0]                        bresp;
      logic                              ar_rdy;
      logic                              rvalid;
      logic [31:0]                       rdata;
      logic [1:0]                        rresp;
   } drb_state_t;

endpackage : drb_pkg

// file: drb_ram32x4.sv
// 32x4 distributed RAM block with separate write and read ports, plus
// an AXI4-Lite slave for mode control, status and configuration clear.
// Assumes user logic on aclk drives the RAM ports; sector_clk is foreign.
`timescale 1ns/1ps
`include "drb_consts.svh"

// Notes on behaviour
// (RULE_01) Store 32 nibbles, separate write/read ports
// (RULE_02) Accept 4-bit write data word
// (RULE_03) Present 4-bit read data word
// (RULE_04) 5-bit write address picks written nibble
// (RULE_05) Separate 5-bit read address picks output
// (RULE_06) Right-most instance: read address tied off
// (RULE_07) Single-port: shared address, bidirectional data
// (RULE_08) Reads and writes proceed independently
// (RULE_09) Read path follows contents, no write clock
// (RULE_10) Front latch passes at load 1, holds 0
// (RULE_11) Address, enable, data pass front latches
// (RULE_12) Front and memory latch form edge flop
// (RULE_13) Nibble follows only addressed, load, enable low
// (RULE_14) Both clock muxes switch together
// (RULE_15) Write clock from upper-left sector column
// (RULE_16) Clear write during configuration empties memory
// (RULE_17) User logic supplies enables, addresses, data
// (RULE_18) Output enable high leaves read data undriven
// (RULE_19) Async write while enable low, then holds
module drb_ram32x4 #(
   parameter bit RIGHTMOST = 1'h0
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [31:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [31:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 sector_clk,
   // (RULE_04) Write address
   input  wire logic [`DRB_AW-1:0]   wr_addr,
   // (RULE_02) Write data word
   input  wire logic [`DRB_DW-1:0]   wr_data,
   input  wire logic                 wr_en_n,
   input  wire logic                 output_enable_n,
   // (RULE_05) Separate read address
   input  wire logic [`DRB_AW-1:0]   rd_addr,
   // (RULE_03) Read data word
   output logic [`DRB_DW-1:0]        rd_data,
   output logic                      rd_data_oe,
   output logic [`DRB_DW-1:0]        port_data_out,
   output logic                      port_data_oe
);

   // (RULE_01) State holds 32 nibbles
   drb_pkg::drb_state_t st_reg;
   drb_pkg::drb_state_t st_next;

   logic                 single_mode;
   logic                 sync_mode;
   logic                 fe_load;
   logic                 mem_load;
   logic [`DRB_AW-1:0]   raddr;
   logic [`DRB_DW-1:0]   rd_pick;
   logic                 wr_commit;
   logic                 clr_fire;
   logic [31:0]          status_word;

   // (RULE_06) Tie-off forces single port
   assign single_mode = st_reg.ctrl[`DRB_CTRL_SINGLE] | RIGHTMOST;
   assign sync_mode   = st_reg.ctrl[`DRB_CTRL_SYNC];

   // (RULE_14) Muxes share one select
   assign fe_load  = sync_mode ? ~st_reg.wclk_s : 1'h1;
   assign mem_load = sync_mode ? st_reg.wclk_s : 1'h1;

   // (RULE_07) Shared address in single port
   assign raddr   = single_mode ? wr_addr : rd_addr;
   // (RULE_09) Read decode needs no write clock
   assign rd_pick = st_reg.mem[raddr];

   assign wr_commit = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
   // (RULE_16) Clear only honoured in configuration
   assign clr_fire  = wr_commit & (st_reg.aw_addr == `DRB_OFF_CLEAR)
                      & st_reg.ctrl[`DRB_CTRL_CFG];

   always_comb begin
      status_word = '0;
      status_word[`DRB_ST_SYNC]   = sync_mode;
      status_word[`DRB_ST_SINGLE] = single_mode;
      status_word[`DRB_ST_CFG]    = st_reg.ctrl[`DRB_CTRL_CFG];
      status_word[`DRB_ST_WCLK]   = st_reg.wclk_s;
      status_word[`DRB_ST_WEN_N]  = st_reg.fe_wen_n;
      status_word[`DRB_ST_ADDR_HI:`DRB_ST_ADDR_LO] = st_reg.fe_addr;
      status_word[`DRB_ST_DATA_HI:`DRB_ST_DATA_LO] = st_reg.fe_data;
   end

   always_comb begin
      st_next = st_reg;

      // (RULE_15) Sector clock through three stages
      st_next.sync1 = sector_clk;
      st_next.sync2 = st_reg.sync1;
      st_next.sync3 = st_reg.sync2;
      if (st_reg.sync2 == st_reg.sync3) begin
         st_next.wclk_s = st_reg.sync3;
      end

      // (RULE_10) Front latches pass or hold
      // (RULE_11) Address, enable and data latched
      if (fe_load) begin
         st_next.fe_addr  = wr_addr;
         st_next.fe_wen_n = wr_en_n;
         st_next.fe_data  = wr_data;
      end

      // (RULE_13) Only the addressed nibble follows
      // (RULE_12) Memory loads while front holds
      // (RULE_19) Async write tracks enable low
      if (mem_load && !st_reg.fe_wen_n) begin
         st_next.mem[st_reg.fe_addr] = st_reg.fe_data;
      end
      if (clr_fire) begin
         st_next.mem = '0;
      end

      // (RULE_08) Read path independent of writes
      st_next.rd_data       = rd_pick;
      st_next.port_data_out = rd_pick;
      // (RULE_18) Undriven while enable is high
      st_next.rd_data_oe    = ~output_enable_n & ~single_mode;
      // Release the shared port one cycle after an incoming write enable is seen
      st_next.port_data_oe  = ~output_enable_n & single_mode & wr_en_n;

      // Write address and data taken in either order
      if (s_axi_awvalid && st_reg.aw_rdy) begin
         st_next.aw_got  = 1'h1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.w_rdy) begin
         st_next.w_got  = 1'h1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      if (wr_commit) begin
         st_next.aw_got = 1'h0;
         st_next.w_got  = 1'h0;
         st_next.bvalid = 1'h1;
         st_next.bresp  = `DRB_RESP_OKAY;
         case (st_reg.aw_addr)
            `DRB_OFF_CTRL: begin
               if (st_reg.w_strb[0]) begin
                  st_next.ctrl = st_reg.w_data[`DRB_CTRL_W-1:0];
               end
            end
            `DRB_OFF_STATUS, `DRB_OFF_CLEAR: begin
               st_next.bresp = `DRB_RESP_OKAY;
            end
            default: begin
               st_next.bresp = `DRB_RESP_DECERR;
            end
         endcase
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'h0;
      end
      st_next.aw_rdy = ~st_next.aw_got & ~st_next.bvalid;
      st_next.w_rdy  = ~st_next.w_got & ~st_next.bvalid;

      if (s_axi_arvalid && st_reg.ar_rdy) begin
         st_next.rvalid = 1'h1;
         st_next.rresp  = `DRB_RESP_OKAY;
         case (s_axi_araddr)
            `DRB_OFF_CTRL: begin
               st_next.rdata = {{(32-`DRB_CTRL_W){1'h0}}, st_reg.ctrl};
            end
            `DRB_OFF_STATUS: begin
               st_next.rdata = status_word;
            end
            `DRB_OFF_CLEAR: begin
               st_next.rdata = '0;
            end
            default: begin
               st_next.rdata = '0;
               st_next.rresp = `DRB_RESP_DECERR;
            end
         endcase
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'h0;
      end
      st_next.ar_rdy = ~st_next.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg      <= '0;
         st_reg.ctrl <= `DRB_CTRL_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.aw_rdy;
   assign s_axi_wready  = st_reg.w_rdy;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = st_reg.ar_rdy;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;
   assign rd_data       = st_reg.rd_data;
   assign rd_data_oe    = st_reg.rd_data_oe;
   assign port_data_out = st_reg.port_data_out;
   assign port_data_oe  = st_reg.port_data_oe;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_clk_high;
      sync_mode && st_reg.wclk_s && !clr_fire;
   endsequence

   // First high cycle still writes the nibble latched before the rise
   sequence s_clk_held;
      s_clk_high ##1 s_clk_high ##1 s_clk_high;
   endsequence

   property p_rd_follow;
      1 |=> st_reg.rd_data == $past(rd_pick);
   endproperty
   a_rd_follow: assert property (p_rd_follow) // RULE_09
      else $error("read data does not follow addressed nibble");

   property p_oe_off;
      output_enable_n |=> !rd_data_oe && !port_data_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) // RULE_18
      else $error("data driven while output enable high");

   property p_oe_on;
      !output_enable_n && !single_mode |=> rd_data_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) // RULE_03
      else $error("read data not driven while enabled");

   property p_hold;
      (!mem_load || st_reg.fe_wen_n) && !clr_fire |=> $stable(st_reg.mem);
   endproperty
   a_hold: assert property (p_hold) // RULE_13
      else $error("memory changed without a write");

   property p_write;
      mem_load && !st_reg.fe_wen_n && !clr_fire
         |=> st_reg.mem[$past(st_reg.fe_addr)] == $past(st_reg.fe_data);
   endproperty
   a_write: assert property (p_write) // RULE_19
      else $error("addressed nibble did not take write data");

   property p_fe_pass;
      fe_load |=> st_reg.fe_addr == $past(wr_addr)
                  && st_reg.fe_data == $past(wr_data);
   endproperty
   a_fe_pass: assert property (p_fe_pass) // RULE_10
      else $error("front latch did not pass input");

   property p_fe_hold;
      !fe_load |=> $stable(st_reg.fe_addr) && $stable(st_reg.fe_wen_n);
   endproperty
   a_fe_hold: assert property (p_fe_hold) // RULE_11
      else $error("front latch changed while closed");

   property p_mux_pair;
      fe_load != mem_load || !sync_mode;
   endproperty
   a_mux_pair: assert property (p_mux_pair) // RULE_14
      else $error("clock muxes not switching together");

   property p_async_open;
      !sync_mode |-> fe_load && mem_load;
   endproperty
   a_async_open: assert property (p_async_open) // RULE_14
      else $error("latches not transparent in async mode");

   property p_edge_only;
      s_clk_held |-> $stable(st_reg.mem);
   endproperty
   a_edge_only: assert property (p_edge_only) // RULE_12
      else $error("memory moved while write clock stayed high");

   property p_clear;
      clr_fire |=> st_reg.mem == '0;
   endproperty
   a_clear: assert property (p_clear) // RULE_16
      else $error("configuration clear left memory contents");

   property p_tie_off;
      RIGHTMOST |-> single_mode && raddr == wr_addr;
   endproperty
   a_tie_off: assert property (p_tie_off) // RULE_06
      else $error("right-most block not single port");

   property p_bresp_after;
      wr_commit |=> s_axi_bvalid ##0 !s_axi_awready;
   endproperty
   a_bresp_after: assert property (p_bresp_after)
      else $error("write answer missing after commit");

   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped before it was taken");

   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped before it was taken");

   property p_port_yield;
      !wr_en_n |=> !port_data_oe;
   endproperty
   a_port_yield: assert property (p_port_yield) // RULE_07
      else $error("shared data driven during a write");

   property p_single_quiet;
      single_mode |=> !rd_data_oe;
   endproperty
   a_single_quiet: assert property (p_single_quiet) // RULE_07
      else $error("separate read output driven in single port");

   property p_wclk_agree;
      st_reg.sync2 == st_reg.sync3 |=> st_reg.wclk_s == $past(st_reg.sync3);
   endproperty
   a_wclk_agree: assert property (p_wclk_agree) // RULE_15
      else $error("write clock ignored settled sector clock");

   property p_wclk_hold;
      st_reg.sync2 != st_reg.sync3 |=> $stable(st_reg.wclk_s);
   endproperty
   a_wclk_hold: assert property (p_wclk_hold) // RULE_15
      else $error("write clock moved on unsettled sector clock");

endmodule : drb_ram32x4

// file: drb_user.sv
// User logic beside the RAM ports: addresses, data and enables.
// Assumes it shares aclk with the block; the bench calls its tasks.
`timescale 1ns/1ps
`include "drb_consts.svh"
module drb_user (
   input  wire logic          aclk,
   output logic [`DRB_AW-1:0] wr_addr,
   output logic [`DRB_DW-1:0] wr_data,
   output logic               wr_en_n,
   output logic               output_enable_n,
   output logic [`DRB_AW-1:0] rd_addr
);
   initial begin
      wr_addr = 5'h00;
      wr_data = 4'h0;
      wr_en_n = 1'h1;
      output_enable_n = 1'h0;
      rd_addr = 5'h00;
   end
   task automatic drive(input logic [4:0] a, input logic [3:0] d, input logic en_n);
      @(posedge aclk);
      wr_addr <= a;
      wr_data <= d;
      wr_en_n <= en_n;
   endtask : drive
   task automatic poke(input logic [4:0] a, input logic [3:0] d);
      drive(a, d, 1'h0);
      // Released data flips so a stale value cannot pass
      drive(a, ~d, 1'h1);
   endtask : poke
   task automatic look(input logic [4:0] a, input logic oe_n);
      @(posedge aclk);
      rd_addr <= a;
      output_enable_n <= oe_n;
      repeat (2) @(posedge aclk);
   endtask : look
endmodule : drb_user

// file: distributed_ram_block_32x4_tb.sv
// Self-checking bench for the 32x4 RAM block and its AXI4-Lite slave.
// Assumes drb_consts.svh on the include path; one 100 MHz clock.
`timescale 1ns/1ps
`include "drb_consts.svh"
module distributed_ram_block_32x4_tb;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0, sector_clk = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, wr_en_n, output_enable_n;
   logic        rd_data_oe, port_data_oe, edge_rd_data_oe, edge_port_data_oe;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rd;
   logic [4:0]  wr_addr, rd_addr;
   logic [3:0]  wr_data, u_data, rd_data, port_data_out, edge_port_data_out;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   always #5 aclk = ~aclk;
   // Shared data wire when the block drives it
   assign wr_data = port_data_oe ? port_data_out : u_data;
   drb_user i_drb_user (.aclk(aclk), .wr_addr(wr_addr), .wr_data(u_data),
      .wr_en_n(wr_en_n), .output_enable_n(output_enable_n), .rd_addr(rd_addr));
   drb_ram32x4 i_drb_ram32x4 (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sector_clk(sector_clk), .wr_addr(wr_addr),
      .wr_data(wr_data), .wr_en_n(wr_en_n), .output_enable_n(output_enable_n),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
      .port_data_out(port_data_out), .port_data_oe(port_data_oe));
   // Right-most copy: its read address is tied off inside
   drb_ram32x4 #(.RIGHTMOST(1'h1)) i_drb_ram32x4_edge (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
      .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
      .sector_clk(sector_clk), .wr_addr(wr_addr), .wr_data(wr_data), .wr_en_n(wr_en_n),
      .output_enable_n(output_enable_n), .rd_addr(rd_addr), .rd_data(),
      .rd_data_oe(edge_rd_data_oe), .port_data_out(edge_port_data_out),
      .port_data_oe(edge_port_data_oe));
   task automatic wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // Bounded wait; running out ends the run
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 40) begin
         n_mismatch++;
         wrap_up();
      end
   endtask : tick
   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         tick(n);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk(bresp, e);
   endtask : axw
   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         tick(n);
         if (arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      d = rdata;
      r = rresp;
   endtask : axr
   task automatic rd_chk(input logic [4:0] a, input logic [3:0] e);
      i_drb_user.look(a, 1'h0);
      chk(rd_data, e);
   endtask : rd_chk
   task automatic t_regs;
      axr(`DRB_OFF_CTRL, rd, resp);
      chk(rd, 32'h0);
      axr(32'h0000_000c, rd, resp);
      chk(resp, `DRB_RESP_DECERR);
      axw(32'h0000_0010, 32'h0, `DRB_RESP_DECERR);
   endtask : t_regs
   task automatic t_async;
      for (int i = 0; i < 32; i++) i_drb_user.poke(i[4:0], i[3:0] ^ 4'h5);
      for (int i = 0; i < 32; i++) rd_chk(i[4:0], i[3:0] ^ 4'h5);
      // Read held on word 0 while word 31 is written
      rd_chk(5'h0, 4'h5);
      i_drb_user.poke(5'h1f, 4'hc);
      repeat (2) @(posedge aclk);
      chk(rd_data, 4'h5);
      rd_chk(5'h1f, 4'hc);
      i_drb_user.drive(5'h2, 4'hf, 1'h1);
      i_drb_user.drive(5'h2, 4'hf, 1'h1);
      rd_chk(5'h2, 4'h7);
   endtask : t_async
   task automatic t_oe;
      i_drb_user.look(5'h0, 1'h1);
      chk(rd_data_oe, 1'h0);
      i_drb_user.look(5'h0, 1'h0);
      chk(rd_data_oe, 1'h1);
      chk(edge_port_data_oe, 1'h1);
      chk(edge_port_data_out, 4'h7);
      chk(edge_rd_data_oe, 1'h0);
   endtask : t_oe
   task automatic t_sync;
      axw(`DRB_OFF_CTRL, 32'h1, `DRB_RESP_OKAY);
      i_drb_user.drive(5'h7, 4'h9, 1'h0);
      repeat (8) @(posedge aclk);
      rd_chk(5'h7, 4'h2);
      sector_clk <= 1'h1;
      repeat (8) @(posedge aclk);
      axr(`DRB_OFF_STATUS, rd, resp);
      chk(rd[`DRB_ST_WCLK], 1'h1);
      // New inputs while the write clock is high must not land
      i_drb_user.drive(5'h7, 4'h6, 1'h0);
      repeat (8) @(posedge aclk);
      sector_clk <= 1'h0;
      repeat (8) @(posedge aclk);
      i_drb_user.drive(5'h7, 4'h6, 1'h1);
      rd_chk(5'h7, 4'h9);
      axw(`DRB_OFF_CTRL, 32'h0, `DRB_RESP_OKAY);
   endtask : t_sync
   task automatic t_clear;
      axw(`DRB_OFF_CLEAR, 32'h1, `DRB_RESP_OKAY);
      rd_chk(5'h0, 4'h5);
      axw(`DRB_OFF_CTRL, 32'h4, `DRB_RESP_OKAY);
      axw(`DRB_OFF_CLEAR, 32'h0, `DRB_RESP_OKAY);
      rd_chk(5'h0, 4'h0);
      rd_chk(5'h1f, 4'h0);
      axw(`DRB_OFF_CTRL, 32'h0, `DRB_RESP_OKAY);
   endtask : t_clear
   task automatic t_single;
      axw(`DRB_OFF_CTRL, 32'h2, `DRB_RESP_OKAY);
      // Block must let go of the shared data before the user writes
      i_drb_user.look(5'h0, 1'h1);
      chk(port_data_oe, 1'h0);
      i_drb_user.poke(5'h4, 4'hb);
      // Read address ignored here
      i_drb_user.look(5'h0, 1'h0);
      chk(port_data_oe, 1'h1);
      chk(port_data_out, 4'hb);
      chk(rd_data_oe, 1'h0);
   endtask : t_single
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs();
      t_async();
      t_oe();
      t_sync();
      t_clear();
      t_single();
      wrap_up();
   end
endmodule : distributed_ram_block_32x4_tb
